//--- verilog/cmd_cfg_pkg.sv
// Constants shared by the command behaviour configuration bank
package cmd_cfg_pkg;
    // Instruction codes
    localparam logic [7:0] OP_REG_READ = 8'h65;
    localparam logic [7:0] OP_REG_WRITE = 8'h71;
    localparam logic [7:0] OP_BURST_SET = 8'hC0;
    localparam logic [7:0] OP_CODE_30 = 8'h30;
    localparam logic [7:0] OP_LEGACY_RESET = 8'hF0;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_BLOCK_ERASE_3B = 8'hD8;
    localparam logic [7:0] OP_BLOCK_ERASE_4B = 8'hDC;

    // Register addresses seen by the generic register commands
    localparam logic [23:0] ADDR_CMD_NV = 24'h000004;
    localparam logic [23:0] ADDR_BURST_NV = 24'h000005;
    localparam logic [23:0] ADDR_CMD_V = 24'h800004;
    localparam logic [23:0] ADDR_BURST_V = 24'h800005;

    // Command configuration field positions
    localparam int CMD_BLANK_CHECK_BIT = 5;
    localparam int CMD_PAGE_WRAP_BIT = 4;
    localparam int CMD_PARAM_DISABLE_BIT = 3;
    localparam int CMD_RESUME_SELECT_BIT = 2;
    localparam int CMD_BLOCK_SIZE_BIT = 1;
    localparam int CMD_LEGACY_RESET_BIT = 0;
    localparam logic [7:0] CMD_WRITABLE_MASK = 8'h3F;
    localparam logic [7:0] CMD_V_WRITE_MASK = 8'h37;

    // Burst configuration field positions
    localparam int BURST_WRAP_DISABLE_BIT = 4;
    localparam int BURST_LEN_LSB = 0;
    localparam logic [7:0] BURST_MASK = 8'h13;

    // Values after power-on
    localparam logic [7:0] CMD_NV_RESET = 8'h00;
    localparam logic [7:0] BURST_NV_RESET = 8'h00;

    // Page buffer geometry
    localparam logic [8:0] PAGE_SMALL_MASK = 9'h0FF;
    localparam logic [8:0] PAGE_LARGE_MASK = 9'h1FF;

    // Parameter sector overlay size in bytes
    localparam int PARAM_REGION_BYTES = 32768;

    typedef enum logic [1:0] {
        ERS_IDLE,
        ERS_SCAN
    } erase_state_t;
endpackage

//--- verilog/cmd_cfg_bank.sv
// Command behaviour configuration bank of the serial flash
`timescale 1ns/1ps
module cmd_cfg_bank #(
    parameter int ARRAY_ADDR_W = 24,
    parameter bit PARAM_AT_TOP = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    // Hardware reset pin, active low, asynchronous to clk
    input wire logic hw_reset_n,
    // Decoded command from the serial front end
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    // Register read answer
    output logic rd_valid,
    output logic [7:0] rd_data,
    // Command side effects
    output logic resume_pulse,
    output logic clear_status_pulse,
    output logic soft_reset_pulse,
    // Live settings
    output logic blank_check_en,
    output logic page_buffer_512,
    output logic param_sectors_present,
    output logic block_erase_256k,
    output logic legacy_reset_en,
    output logic [1:0] burst_wrap_length,
    // Erase request and array sector scan
    input wire logic erase_req,
    input wire logic [ARRAY_ADDR_W-1:0] erase_addr,
    input wire logic prior_erase_ok,
    input wire logic scan_zero_found,
    input wire logic scan_done,
    output logic scan_busy,
    output logic erase_go,
    output logic erase_skip,
    output logic erase_hits_param,
    // Page buffer loading
    input wire logic pgm_start,
    input wire logic [8:0] pgm_offset,
    input wire logic pgm_byte,
    output logic [8:0] pgm_buf_index,
    // Main array read wrap qualification
    input wire logic read_is_array,
    input wire logic read_is_quad_io,
    output logic burst_wrap_active
);

    initial begin
        if (ARRAY_ADDR_W < 16 || ARRAY_ADDR_W > 32) begin
            $error("cmd_cfg_bank: ARRAY_ADDR_W out of range");
        end
    end

    typedef struct packed {
        logic [7:0] cmd_nv;
        logic [7:0] cmd_v;
        logic [7:0] burst_nv;
        logic [7:0] burst_v;
        logic reset_armed;
        logic hw_sync1;
        logic hw_sync2;
        logic rd_valid;
        logic [7:0] rd_data;
        logic resume_p;
        logic clear_p;
        logic soft_reset_p;
        cmd_cfg_pkg::erase_state_t ers;
        logic erase_go;
        logic erase_skip;
        logic [8:0] buf_index;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Next load slot: the mask decides the wrap point
    function automatic logic [8:0] next_index(input logic [8:0] idx, input logic wide);
        logic [8:0] mask;
        mask = wide ? cmd_cfg_pkg::PAGE_LARGE_MASK : cmd_cfg_pkg::PAGE_SMALL_MASK;
        next_index = (idx + 9'h001) & mask;
    endfunction

    logic hw_reset_req;
    logic do_reload;
    logic is_reg_write;
    logic [ARRAY_ADDR_W-1:0] region_base;

    assign hw_reset_req = ~state_reg.hw_sync2;
    assign is_reg_write = cmd_valid && cmd_opcode == cmd_cfg_pkg::OP_REG_WRITE;
    assign do_reload = state_reg.soft_reset_p || hw_reset_req;

    always_comb begin
        state_next = state_reg;
        state_next.hw_sync1 = hw_reset_n;
        state_next.hw_sync2 = state_reg.hw_sync1;
        state_next.rd_valid = 1'b0;
        state_next.resume_p = 1'b0;
        state_next.clear_p = 1'b0;
        state_next.soft_reset_p = 1'b0;
        state_next.erase_go = 1'b0;
        state_next.erase_skip = 1'b0;

        if (cmd_valid) begin
            // Only an immediately following 99h completes the reset pair
            state_next.reset_armed = cmd_opcode == cmd_cfg_pkg::OP_RESET_ENABLE;
            if (cmd_opcode == cmd_cfg_pkg::OP_RESET && state_reg.reset_armed) begin
                state_next.soft_reset_p = 1'b1;
            end
            if (cmd_opcode == cmd_cfg_pkg::OP_LEGACY_RESET
                && state_reg.cmd_v[cmd_cfg_pkg::CMD_LEGACY_RESET_BIT]) begin
                state_next.soft_reset_p = 1'b1;
            end
            if (cmd_opcode == cmd_cfg_pkg::OP_CODE_30) begin
                if (state_reg.cmd_v[cmd_cfg_pkg::CMD_RESUME_SELECT_BIT]) begin
                    state_next.resume_p = 1'b1;
                end else begin
                    state_next.clear_p = 1'b1;
                end
            end
            if (cmd_opcode == cmd_cfg_pkg::OP_REG_READ) begin
                state_next.rd_valid = 1'b1;
                if (cmd_addr == cmd_cfg_pkg::ADDR_CMD_NV) begin
                    state_next.rd_data = state_reg.cmd_nv;
                end else if (cmd_addr == cmd_cfg_pkg::ADDR_CMD_V) begin
                    state_next.rd_data = state_reg.cmd_v;
                end else if (cmd_addr == cmd_cfg_pkg::ADDR_BURST_NV) begin
                    state_next.rd_data = state_reg.burst_nv;
                end else if (cmd_addr == cmd_cfg_pkg::ADDR_BURST_V) begin
                    state_next.rd_data = state_reg.burst_v;
                end else begin
                    state_next.rd_data = 8'h00;
                end
            end
        end

        if (is_reg_write) begin
            // One-time bits can only move away from the shipped zero
            if (cmd_addr == cmd_cfg_pkg::ADDR_CMD_NV) begin
                state_next.cmd_nv = state_reg.cmd_nv
                    | (cmd_wdata & cmd_cfg_pkg::CMD_WRITABLE_MASK);
            end else if (cmd_addr == cmd_cfg_pkg::ADDR_CMD_V) begin
                // Parameter-sector bit is read only here, so a stray host write is harmless
                state_next.cmd_v = (state_reg.cmd_v & ~cmd_cfg_pkg::CMD_V_WRITE_MASK)
                    | (cmd_wdata & cmd_cfg_pkg::CMD_V_WRITE_MASK);
            end else if (cmd_addr == cmd_cfg_pkg::ADDR_BURST_NV) begin
                state_next.burst_nv = state_reg.burst_nv
                    | (cmd_wdata & cmd_cfg_pkg::BURST_MASK);
            end else if (cmd_addr == cmd_cfg_pkg::ADDR_BURST_V) begin
                state_next.burst_v = cmd_wdata & cmd_cfg_pkg::BURST_MASK;
            end
        end
        if (cmd_valid && cmd_opcode == cmd_cfg_pkg::OP_BURST_SET) begin
            state_next.burst_v = cmd_wdata & cmd_cfg_pkg::BURST_MASK;
        end

        if (do_reload) begin
            state_next.cmd_v = state_reg.cmd_nv;
            state_next.burst_v = state_reg.burst_nv;
            state_next.reset_armed = 1'b0;
        end

        case (state_reg.ers)
            cmd_cfg_pkg::ERS_IDLE: begin
                if (erase_req && !do_reload) begin
                    if (!state_reg.cmd_v[cmd_cfg_pkg::CMD_BLANK_CHECK_BIT]
                        || !prior_erase_ok) begin
                        state_next.erase_go = 1'b1;
                    end else begin
                        state_next.ers = cmd_cfg_pkg::ERS_SCAN;
                    end
                end
            end
            cmd_cfg_pkg::ERS_SCAN: begin
                if (do_reload) begin
                    state_next.ers = cmd_cfg_pkg::ERS_IDLE;
                end else if (scan_zero_found) begin
                    state_next.erase_go = 1'b1;
                    state_next.ers = cmd_cfg_pkg::ERS_IDLE;
                end else if (scan_done) begin
                    state_next.erase_skip = 1'b1;
                    state_next.ers = cmd_cfg_pkg::ERS_IDLE;
                end
            end
            default: begin
                state_next.ers = cmd_cfg_pkg::ERS_IDLE;
            end
        endcase

        if (pgm_start) begin
            state_next.buf_index = pgm_offset
                & (state_reg.cmd_v[cmd_cfg_pkg::CMD_PAGE_WRAP_BIT]
                   ? cmd_cfg_pkg::PAGE_LARGE_MASK : cmd_cfg_pkg::PAGE_SMALL_MASK);
        end else if (pgm_byte) begin
            state_next.buf_index = next_index(state_reg.buf_index,
                state_reg.cmd_v[cmd_cfg_pkg::CMD_PAGE_WRAP_BIT]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.cmd_nv <= cmd_cfg_pkg::CMD_NV_RESET;
            state_reg.cmd_v <= cmd_cfg_pkg::CMD_NV_RESET;
            state_reg.burst_nv <= cmd_cfg_pkg::BURST_NV_RESET;
            state_reg.burst_v <= cmd_cfg_pkg::BURST_NV_RESET;
            state_reg.hw_sync1 <= 1'b1;
            state_reg.hw_sync2 <= 1'b1;
            state_reg.ers <= cmd_cfg_pkg::ERS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Parameter region: top or bottom 32 kB of the array
    assign region_base = PARAM_AT_TOP
        ? ARRAY_ADDR_W'({ARRAY_ADDR_W{1'b1}} - ARRAY_ADDR_W'(cmd_cfg_pkg::PARAM_REGION_BYTES - 1))
        : '0;
    assign erase_hits_param = param_sectors_present
        && (erase_addr >= region_base)
        && (erase_addr - region_base < ARRAY_ADDR_W'(cmd_cfg_pkg::PARAM_REGION_BYTES));

    assign rd_valid = state_reg.rd_valid;
    assign rd_data = state_reg.rd_data;
    assign resume_pulse = state_reg.resume_p;
    assign clear_status_pulse = state_reg.clear_p;
    assign soft_reset_pulse = state_reg.soft_reset_p;
    assign blank_check_en = state_reg.cmd_v[cmd_cfg_pkg::CMD_BLANK_CHECK_BIT];
    assign page_buffer_512 = state_reg.cmd_v[cmd_cfg_pkg::CMD_PAGE_WRAP_BIT];
    assign param_sectors_present =
        !state_reg.cmd_v[cmd_cfg_pkg::CMD_PARAM_DISABLE_BIT];
    assign block_erase_256k = state_reg.cmd_v[cmd_cfg_pkg::CMD_BLOCK_SIZE_BIT];
    assign legacy_reset_en = state_reg.cmd_v[cmd_cfg_pkg::CMD_LEGACY_RESET_BIT];
    assign burst_wrap_length = state_reg.burst_v[cmd_cfg_pkg::BURST_LEN_LSB +: 2];
    assign burst_wrap_active = read_is_array && read_is_quad_io
        && !state_reg.burst_v[cmd_cfg_pkg::BURST_WRAP_DISABLE_BIT];
    assign scan_busy = state_reg.ers == cmd_cfg_pkg::ERS_SCAN;
    assign erase_go = state_reg.erase_go;
    assign erase_skip = state_reg.erase_skip;
    assign pgm_buf_index = state_reg.buf_index;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic cmd_v_hi_zero;
    assign cmd_v_hi_zero = state_reg.cmd_v[7:6] == 2'b00;

    chk_otp_no_clear: assert property (($past(state_reg.cmd_nv) & ~state_reg.cmd_nv) == 8'h00)
        else $error("boot command bit went back to zero");
    chk_reserved_zero: assert property (state_reg.cmd_nv[7:6] == 2'b00 && cmd_v_hi_zero)
        else $error("reserved bits not zero");
    chk_reset_reload: assert property (soft_reset_pulse |=>
        state_reg.cmd_v == $past(state_reg.cmd_nv) && state_reg.burst_v == $past(state_reg.burst_nv))
        else $error("reset did not reload live bits");
    chk_pair_reset: assert property (cmd_valid && cmd_opcode == cmd_cfg_pkg::OP_RESET_ENABLE && !do_reload
        ##1 cmd_valid && cmd_opcode == cmd_cfg_pkg::OP_RESET && !hw_reset_req |=> soft_reset_pulse)
        else $error("66h 99h pair did not reset");
    chk_legacy_gate: assert property (cmd_valid && cmd_opcode == cmd_cfg_pkg::OP_LEGACY_RESET
        && !legacy_reset_en && !state_reg.reset_armed |=> !soft_reset_pulse)
        else $error("F0h reset while disabled");
    chk_code30_route: assert property (cmd_valid && cmd_opcode == cmd_cfg_pkg::OP_CODE_30
        |=> resume_pulse == $past(state_reg.cmd_v[2]) && clear_status_pulse != resume_pulse)
        else $error("30h routed wrongly");
    chk_no_check_go: assert property (erase_req && !blank_check_en && !do_reload
        && !scan_busy |=> erase_go) else $error("erase did not start unconditionally");
    chk_scan_skip: assert property (scan_busy && scan_done && !scan_zero_found && !do_reload
        |=> erase_skip && !erase_go) else $error("blank sector not skipped");
    chk_small_wrap: assert property (pgm_byte && !pgm_start && !page_buffer_512
        && pgm_buf_index == 9'h0FF |=> pgm_buf_index == 9'h000)
        else $error("256-byte wrap failed");
    chk_param_locked: assert property (is_reg_write && cmd_addr == cmd_cfg_pkg::ADDR_CMD_V
        && !do_reload |=> $stable(state_reg.cmd_v[3])) else $error("live parameter bit changed");

    cov_blank_skip: cover property (scan_busy ##[1:20] erase_skip);
    cov_pair_reset: cover property (soft_reset_pulse);
    cov_nv_program: cover property (is_reg_write && cmd_addr == cmd_cfg_pkg::ADDR_CMD_NV);
endmodule

//--- dv/flash_host_model.sv
// Host controller and array scan model facing the configuration bank
`timescale 1ns/1ps
module flash_host_model (
    // Clock
    input wire logic clk,
    // Command port
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [23:0] cmd_addr,
    output logic [7:0] cmd_wdata,
    // Array scan
    input wire logic scan_busy,
    input wire logic sector_blank,
    output logic scan_zero_found,
    output logic scan_done
);
    logic boot_param_bit = 1'b0;
    logic slow = 1'b0;
    int scan_cnt = 0;
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_addr = 24'h000000;
        cmd_wdata = 8'h00;
        scan_zero_found = 1'b0;
        scan_done = 1'b0;
    end
    // One command per call, launched after an edge and held for exactly one edge
    task automatic send(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (op == cmd_cfg_pkg::OP_REG_WRITE && addr == cmd_cfg_pkg::ADDR_CMD_V) begin
            d[3] = boot_param_bit;
        end
        if (op == cmd_cfg_pkg::OP_REG_WRITE && addr == cmd_cfg_pkg::ADDR_CMD_NV) begin
            boot_param_bit = boot_param_bit | data[3];
        end
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_opcode <= op;
        cmd_addr <= addr;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Released qualifiers show garbage so nothing leans on stale values
        cmd_opcode <= ~op;
        cmd_addr <= ~addr;
        cmd_wdata <= ~d;
    endtask
    // Scan answers alternate between prompt and slow
    always @(posedge clk) begin
        scan_zero_found <= 1'b0;
        scan_done <= 1'b0;
        if (!scan_busy) begin
            scan_cnt <= 0;
        end else if (scan_cnt + 1 == (slow ? 5 : 1)) begin
            scan_zero_found <= !sector_blank;
            scan_done <= sector_blank;
            scan_cnt <= 0;
            slow <= !slow;
        end else begin
            scan_cnt <= scan_cnt + 1;
        end
    end
endmodule

//--- dv/flash_command_behavior_config_bench.sv
// Self-checking bench for the command behaviour configuration bank
`timescale 1ns/1ps
module flash_command_behavior_config_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_n = 1'b1;
    logic erase_req = 1'b0;
    logic [23:0] erase_addr = 24'h000000;
    logic prior_erase_ok = 1'b0;
    logic pgm_start = 1'b0;
    logic [8:0] pgm_offset = 9'h000;
    logic pgm_byte = 1'b0;
    logic read_is_array = 1'b0;
    logic read_is_quad_io = 1'b0;
    logic sector_blank = 1'b0;
    logic cmd_valid, rd_valid, resume_pulse, clear_status_pulse, soft_reset_pulse;
    logic [7:0] cmd_opcode, cmd_wdata, rd_data;
    logic [23:0] cmd_addr;
    logic blank_check_en, page_buffer_512, param_sectors_present, block_erase_256k;
    logic legacy_reset_en, scan_zero_found, scan_done, scan_busy, erase_go, erase_skip;
    logic erase_hits_param, burst_wrap_active;
    logic [1:0] burst_wrap_length;
    logic [8:0] pgm_buf_index;
    int mismatches = 0;
    int check_count = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    cmd_cfg_bank dut_u (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rd_valid(rd_valid), .rd_data(rd_data), .resume_pulse(resume_pulse),
        .clear_status_pulse(clear_status_pulse), .soft_reset_pulse(soft_reset_pulse),
        .blank_check_en(blank_check_en), .page_buffer_512(page_buffer_512),
        .param_sectors_present(param_sectors_present), .block_erase_256k(block_erase_256k),
        .legacy_reset_en(legacy_reset_en), .burst_wrap_length(burst_wrap_length),
        .erase_req(erase_req), .erase_addr(erase_addr), .prior_erase_ok(prior_erase_ok),
        .scan_zero_found(scan_zero_found), .scan_done(scan_done), .scan_busy(scan_busy),
        .erase_go(erase_go), .erase_skip(erase_skip), .erase_hits_param(erase_hits_param),
        .pgm_start(pgm_start), .pgm_offset(pgm_offset), .pgm_byte(pgm_byte),
        .pgm_buf_index(pgm_buf_index), .read_is_array(read_is_array),
        .read_is_quad_io(read_is_quad_io), .burst_wrap_active(burst_wrap_active));
    flash_host_model host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .scan_busy(scan_busy),
        .sector_blank(sector_blank), .scan_zero_found(scan_zero_found), .scan_done(scan_done));
    task automatic end_of_test;
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        host_u.send(op, 24'h000000, d);
        #1;
    endtask
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        host_u.send(cmd_cfg_pkg::OP_REG_WRITE, a, d);
        tick();
    endtask
    task automatic rd(input logic [23:0] a, input logic [7:0] exp);
        host_u.send(cmd_cfg_pkg::OP_REG_READ, a, 8'h00);
        #1;
        check({rd_valid, rd_data}, {1'b1, exp});
    endtask
    task automatic pg(input logic start, input logic [8:0] off, input logic [8:0] exp);
        @(posedge clk);
        pgm_start <= start;
        pgm_byte <= !start;
        pgm_offset <= off;
        @(posedge clk);
        pgm_start <= 1'b0;
        pgm_byte <= 1'b0;
        #1;
        check(pgm_buf_index, exp);
    endtask
    // Waits a bounded time for the erase verdict, then compares go and skip together
    task automatic erase(input logic ok, input logic blank, input logic [1:0] exp);
        @(posedge clk);
        erase_req <= 1'b1;
        prior_erase_ok <= ok;
        sector_blank <= blank;
        @(posedge clk);
        erase_req <= 1'b0;
        repeat (12) begin
            #1;
            if (erase_go || erase_skip) break;
            @(posedge clk);
        end
        check({erase_go, erase_skip}, exp);
        check(scan_busy, 1'b0);
        tick();
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(cmd_cfg_pkg::ADDR_CMD_NV, 8'h00);
        rd(cmd_cfg_pkg::ADDR_CMD_V, 8'h00);
        rd(cmd_cfg_pkg::ADDR_BURST_V, 8'h00);
        rd(24'h000077, 8'h00);
        check({param_sectors_present, erase_hits_param}, 2'b11);
        wr(cmd_cfg_pkg::ADDR_CMD_V, 8'hF7);
        rd(cmd_cfg_pkg::ADDR_CMD_V, 8'h37);
        check({blank_check_en, page_buffer_512, block_erase_256k, legacy_reset_en}, 4'hF);
        pg(1'b1, 9'h0FE, 9'h0FE);
        pg(1'b0, 9'h000, 9'h0FF);
        pg(1'b0, 9'h000, 9'h100);
        erase(1'b1, 1'b1, 2'b01);
        erase(1'b1, 1'b0, 2'b10);
        erase(1'b0, 1'b1, 2'b10);
        cmd(cmd_cfg_pkg::OP_CODE_30, 8'h00);
        check({resume_pulse, clear_status_pulse}, 2'b10);
        wr(cmd_cfg_pkg::ADDR_CMD_V, 8'h00);
        check({blank_check_en, page_buffer_512, block_erase_256k, legacy_reset_en}, 4'h0);
        cmd(cmd_cfg_pkg::OP_CODE_30, 8'h00);
        check({resume_pulse, clear_status_pulse}, 2'b01);
        erase(1'b1, 1'b1, 2'b10);
        pg(1'b1, 9'h0FF, 9'h0FF);
        pg(1'b0, 9'h000, 9'h000);
        cmd(cmd_cfg_pkg::OP_LEGACY_RESET, 8'h00);
        check(soft_reset_pulse, 1'b0);
        cmd(cmd_cfg_pkg::OP_BURST_SET, 8'h13);
        rd(cmd_cfg_pkg::ADDR_BURST_V, 8'h13);
        read_is_array <= 1'b1;
        read_is_quad_io <= 1'b1;
        tick();
        check({burst_wrap_length, burst_wrap_active}, 3'b110);
        cmd(cmd_cfg_pkg::OP_BURST_SET, 8'h02);
        tick();
        check({burst_wrap_length, burst_wrap_active}, 3'b101);
        read_is_array <= 1'b0;
        tick();
        check(burst_wrap_active, 1'b0);
        cmd(cmd_cfg_pkg::OP_RESET_ENABLE, 8'h00);
        cmd(cmd_cfg_pkg::OP_RESET, 8'h00);
        check(soft_reset_pulse, 1'b1);
        tick();
        rd(cmd_cfg_pkg::ADDR_BURST_V, 8'h00);
        wr(cmd_cfg_pkg::ADDR_CMD_NV, 8'h09);
        wr(cmd_cfg_pkg::ADDR_CMD_NV, 8'h00);
        rd(cmd_cfg_pkg::ADDR_CMD_NV, 8'h09);
        rd(cmd_cfg_pkg::ADDR_CMD_V, 8'h00);
        wr(cmd_cfg_pkg::ADDR_CMD_V, 8'h01);
        cmd(cmd_cfg_pkg::OP_LEGACY_RESET, 8'h00);
        check(soft_reset_pulse, 1'b1);
        tick();
        check({param_sectors_present, erase_hits_param}, 2'b00);
        wr(cmd_cfg_pkg::ADDR_CMD_V, 8'h36);
        rd(cmd_cfg_pkg::ADDR_CMD_V, 8'h3E);
        hw_reset_n <= 1'b0;
        repeat (5) tick();
        hw_reset_n <= 1'b1;
        repeat (4) tick();
        rd(cmd_cfg_pkg::ADDR_CMD_V, 8'h09);
        end_of_test();
    end
endmodule
